// ### daes_consts.vh
// Purpose: constants for the data abort syndrome encoder
// Assumes: 32-bit Avalon-MM register slave, word offsets in bytes
// Notes: field positions are bit indices of the 25-bit syndrome word
`ifndef DAES_CONSTS_VH
`define DAES_CONSTS_VH

// register byte offsets
`define DAES_OFS_SYND 4'h0
`define DAES_OFS_CTRL 4'h4
`define DAES_OFS_STAT 4'h8

// control bits
`define DAES_CTRL_WIDE 0
`define DAES_CTRL_NV 1
`define DAES_CTRL_RAS 2
`define DAES_CTRL_L1 3
`define DAES_CTRL_RELAX 4
`define DAES_CTRL_W 5
`define DAES_CTRL_RESET 5'h00

// status bits
`define DAES_STAT_CAPT 0
`define DAES_STAT_CNT_LO 8
`define DAES_STAT_CNT_HI 15

// syndrome field positions
`define DAES_B_ISV 24
`define DAES_B_SF 15
`define DAES_B_AR 14
`define DAES_B_NESTED_REDIRECT_FLAG 13
`define DAES_B_T_HI 12
`define DAES_B_T_LO 11
`define DAES_B_FNV 10
`define DAES_B_EA 9
`define DAES_B_CM 8
`define DAES_B_S1W 7
`define DAES_B_WNR 6
`define DAES_SYND_W 25

// fault kinds from the translation logic
`define DAES_FK_ADDR 3'h0
`define DAES_FK_TRAN 3'h1
`define DAES_FK_ACCF 3'h2
`define DAES_FK_PERM 3'h3
`define DAES_FK_SEA 3'h4
`define DAES_FK_WALK 3'h5
`define DAES_FK_RAW 3'h7

// fault status codes
`define DAES_FSC_SEA 6'h10
`define DAES_FSC_WIDE 6'h35
`define DAES_FSC_UNSUP 6'h31
`define DAES_FSC_ADDR_PFX 4'h0
`define DAES_FSC_TRAN_PFX 4'h1
`define DAES_FSC_ACCF_PFX 4'h2
`define DAES_FSC_PERM_PFX 4'h3
`define DAES_FSC_WALK_PFX 4'h5

// error state and wide access type encodings
`define DAES_ERR_RECOV 2'h0
`define DAES_ERR_RSVD 2'h1
`define DAES_ERR_UNCONT 2'h2
`define DAES_ERR_RESTART 2'h3
`define DAES_WT_STATUS 2'h1
`define DAES_WT_PLAIN 2'h2
`define DAES_WT_ZERO 2'h3

`endif

// ### daes_fsc_enc.v
// Purpose: fault status code from fault kind and lookup level
// Assumes: combinational, same clock domain as the caller
// Notes: raw kind passes the pipeline's own code through
`timescale 1ns/1ns
`default_nettype none
`include "daes_consts.vh"

module daes_fsc_enc (
    // fault description
    input wire [2:0] fault_kind,
    input wire [1:0] lookup_level,
    input wire [5:0] raw_code,
    // encoded code
    output reg [5:0] fsc
);

    always @* begin
        case (fault_kind)
            `DAES_FK_ADDR: fsc = {`DAES_FSC_ADDR_PFX, lookup_level};
            `DAES_FK_TRAN: fsc = {`DAES_FSC_TRAN_PFX, lookup_level};
            `DAES_FK_ACCF: fsc = {`DAES_FSC_ACCF_PFX, lookup_level};
            `DAES_FK_PERM: fsc = {`DAES_FSC_PERM_PFX, lookup_level};
            `DAES_FK_SEA: fsc = `DAES_FSC_SEA;
            `DAES_FK_WALK: fsc = {`DAES_FSC_WALK_PFX, lookup_level};
            default: fsc = raw_code;
        endcase
    end

endmodule
`default_nettype wire

// ### daes_pipe_model.sv
// Purpose: load/store pipeline model that raises data aborts
// Assumes: called just after a rising edge of clock
// Notes: fault_kind and fl are inverted once the abort edge has passed; the other attributes hold
`timescale 1ns/1ns
`default_nettype none
module daes_pipe_model (
    // core clock
    input wire logic clock,
    // abort event and attributes
    output logic abort_take,
    output logic [2:0] fault_kind,
    output logic [1:0] lookup_level,
    output logic [5:0] raw_code,
    output logic [1:0] error_state,
    output logic [1:0] insn_wide_form,
    output logic ext_class,
    output logic [13:0] fl
);
    initial begin
        {abort_take, fault_kind, lookup_level, error_state, insn_wide_form, ext_class} = '0;
        fl = 14'h0000;
        raw_code = 6'h35;
    end

    task automatic fire(input logic [2:0] k, input logic [1:0] l, input logic [13:0] f,
            input logic [1:0] e, input logic [1:0] w);
        abort_take <= 1'b1;
        fault_kind <= k;
        lookup_level <= l;
        fl <= f;
        error_state <= e;
        insn_wide_form <= w;
        ext_class <= (k == 3'h4);
        @(posedge clock);
        // stale attributes must never reach the captured word
        abort_take <= 1'b0;
        fault_kind <= ~k;
        fl <= ~f;
        @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ### daes_top.v
// Purpose: builds and holds the data abort syndrome word
// Assumes: pipeline inputs are on the core clock; Avalon-MM slave
// Notes: syndrome captured whole on abort_take while clock_en is high
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "daes_consts.vh"

module daes_top #(
    parameter CNT_W = 8
) (
    // clock, reset, enable
    input wire clock,
    input wire rst_n,
    input wire clock_en,
    // abort event from the load/store pipeline
    input wire abort_take,
    input wire [2:0] fault_kind,
    input wire [1:0] lookup_level,
    input wire [5:0] raw_code,
    // instruction attributes
    input wire insn_syndrome_ok,
    input wire insn_reg_64,
    input wire insn_acq_rel,
    input wire insn_is_write,
    input wire insn_is_atomic,
    input wire atomic_read_faults,
    input wire insn_wide,
    input wire [1:0] insn_wide_form,
    input wire insn_cache_maint,
    input wire insn_addr_xlate,
    input wire insn_zero_op,
    input wire sysreg_redirect,
    // translation attributes
    input wire fault_stage2,
    input wire fault_on_walk,
    input wire far_valid,
    input wire [1:0] error_state,
    input wire ext_class,
    // Avalon-MM slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // syndrome word
    output reg [`DAES_SYND_W-1:0] syndrome_out,
    output reg syndrome_strobe
);

    reg [`DAES_CTRL_W-1:0] ctrl_reg;
    reg captured_reg;
    reg [CNT_W-1:0] count_reg;
    reg ack_reg;
    wire [5:0] fsc;
    wire wide_feat;
    wire nv_feat;
    wire ras_feat;
    wire target_l1;
    wire relax_feat;
    wire kind_tap;
    wire wide_fault;
    wire syndrome_valid;
    wire is_sea;
    wire is_ext;
    wire s2_walk;
    wire cmo_at;
    reg write_direction_flag;
    reg [1:0] type_field;
    reg [1:0] wide_field;
    reg [1:0] err_field;
    reg sf_bit;
    reg ar_bit;
    reg nested_redirect_flag_bit;
    reg fnv_bit;
    reg ea_bit;
    reg s1w_bit;
    reg [`DAES_SYND_W-1:0] synd_next;
    wire req;
    wire take;
    wire wr_take;
    wire rd_take;
    wire clr_capt;

    // decode of a register offset, shared by read and write paths
    function sel;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            sel = (addr == ofs);
        end
    endfunction

    // a reserved error state is reported as the most pessimistic one
    function [1:0] err_norm;
        input [1:0] state;
        begin
            if (state == `DAES_ERR_RSVD) begin
                err_norm = `DAES_ERR_UNCONT;
            end else begin
                err_norm = state;
            end
        end
    endfunction

    // fault kinds that can carry a wide access syndrome
    function is_tap;
        input [2:0] kind;
        begin
            is_tap = (kind == `DAES_FK_TRAN) || (kind == `DAES_FK_ACCF) ||
                (kind == `DAES_FK_PERM);
        end
    endfunction

    daes_fsc_enc u_fsc (
        .fault_kind(fault_kind),
        .lookup_level(lookup_level),
        .raw_code(raw_code),
        .fsc(fsc)
    );

    assign wide_feat = ctrl_reg[`DAES_CTRL_WIDE];
    assign nv_feat = ctrl_reg[`DAES_CTRL_NV];
    assign ras_feat = ctrl_reg[`DAES_CTRL_RAS];
    assign target_l1 = ctrl_reg[`DAES_CTRL_L1];
    assign relax_feat = ctrl_reg[`DAES_CTRL_RELAX];

    // translation, access flag or permission fault
    assign kind_tap = is_tap(fault_kind);
    assign wide_fault = wide_feat && insn_wide && kind_tap;
    assign is_sea = (fsc == `DAES_FSC_SEA);
    assign is_ext = is_sea || (fsc[5:2] == `DAES_FSC_WALK_PFX);
    assign s2_walk = fault_stage2 && fault_on_walk;
    assign cmo_at = (insn_cache_maint || insn_addr_xlate) && !insn_zero_op;

    // no valid instruction syndrome on a stage 2 walk, except for a wide access fault, or on an external abort with recovery
    assign syndrome_valid = wide_fault ||
        (insn_syndrome_ok && !s2_walk && !(ras_feat && is_ext));

    // direction bit
    always @* begin
        if (cmo_at) begin
            write_direction_flag = 1'b1;
        end else if (insn_is_atomic) begin
            // defined value also where an unknown would be allowed
            if (relax_feat && s2_walk) begin
                write_direction_flag = 1'b0;
            end else begin
                write_direction_flag = !atomic_read_faults;
            end
        end else begin
            write_direction_flag = insn_is_write;
        end
    end

    // width flag follows the named register, forced to 1 on a wide access fault, never execution state
    always @* begin
        if (syndrome_valid) begin
            sf_bit = wide_fault | insn_reg_64;
        end else begin
            sf_bit = 1'b0;
        end
    end

    // acquire/release flag
    always @* begin
        if (syndrome_valid) begin
            ar_bit = !wide_fault && insn_acq_rel;
        end else begin
            ar_bit = 1'b0;
        end
    end

    // redirected register move, never in the level-1 syndrome register
    always @* begin
        if (nv_feat && !target_l1) begin
            nested_redirect_flag_bit = sysreg_redirect;
        end else begin
            nested_redirect_flag_bit = 1'b0;
        end
    end

    // wide access type, meaningful only for its own status code
    always @* begin
        if (fsc == `DAES_FSC_WIDE) begin
            wide_field = insn_wide_form;
        end else begin
            wide_field = 2'h0;
        end
    end

    // error state, only after a synchronous external abort
    always @* begin
        if (ras_feat && is_sea) begin
            err_field = err_norm(error_state);
        end else begin
            err_field = 2'h0;
        end
    end

    // bits 12:11 by feature set
    always @* begin
        if (wide_feat) begin
            type_field = wide_field;
        end else begin
            type_field = err_field;
        end
    end

    // fault address validity, only for a non-walk external abort
    always @* begin
        if (is_sea) begin
            fnv_bit = !far_valid;
        end else begin
            fnv_bit = 1'b0;
        end
    end

    // external abort class, zero for every other abort
    always @* begin
        if (is_ext) begin
            ea_bit = ext_class;
        end else begin
            ea_bit = 1'b0;
        end
    end

    // walk flag, zero for aborts other than stage 2
    always @* begin
        if (fault_stage2) begin
            s1w_bit = fault_on_walk;
        end else begin
            s1w_bit = 1'b0;
        end
    end

    always @* begin
        synd_next = {`DAES_SYND_W{1'b0}};
        synd_next[5:0] = fsc;
        synd_next[`DAES_B_ISV] = syndrome_valid;
        synd_next[`DAES_B_SF] = sf_bit;
        synd_next[`DAES_B_AR] = ar_bit;
        synd_next[`DAES_B_NESTED_REDIRECT_FLAG] = nested_redirect_flag_bit;
        synd_next[`DAES_B_T_HI] = type_field[1];
        synd_next[`DAES_B_T_LO] = type_field[0];
        synd_next[`DAES_B_FNV] = fnv_bit;
        synd_next[`DAES_B_EA] = ea_bit;
        synd_next[`DAES_B_CM] = cmo_at;
        synd_next[`DAES_B_S1W] = s1w_bit;
        synd_next[`DAES_B_WNR] = write_direction_flag;
    end

    // cleared at reset although software may not rely on it
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syndrome_out <= {`DAES_SYND_W{1'b0}};
            syndrome_strobe <= 1'b0;
        end else if (clock_en) begin
            syndrome_strobe <= abort_take;
            if (abort_take) begin
                syndrome_out <= synd_next;
            end
        end
    end

    // bus slave: one wait cycle, answer on the second cycle of a request
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_reg;
    assign take = req && ack_reg && clock_en;
    assign wr_take = take && avs_write;
    assign rd_take = req && !ack_reg && clock_en && avs_read;
    assign clr_capt = wr_take && sel(avs_address, `DAES_OFS_STAT) &&
        avs_byteenable[0] && avs_writedata[`DAES_STAT_CAPT];

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else if (clock_en) begin
            ack_reg <= req && !ack_reg;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata <= 32'h0000_0000;
            if (sel(avs_address, `DAES_OFS_SYND)) begin
                avs_readdata[`DAES_SYND_W-1:0] <= syndrome_out;
            end else if (sel(avs_address, `DAES_OFS_CTRL)) begin
                avs_readdata[`DAES_CTRL_W-1:0] <= ctrl_reg;
            end else if (sel(avs_address, `DAES_OFS_STAT)) begin
                avs_readdata[`DAES_STAT_CAPT] <= captured_reg;
                avs_readdata[`DAES_STAT_CNT_LO+CNT_W-1:`DAES_STAT_CNT_LO] <= count_reg;
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `DAES_CTRL_RESET;
        end else if (wr_take && sel(avs_address, `DAES_OFS_CTRL) && avs_byteenable[0]) begin
            ctrl_reg <= avs_writedata[`DAES_CTRL_W-1:0];
        end
    end

    // capture flag: a new abort wins over a clear in the same cycle
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            captured_reg <= 1'b0;
            count_reg <= {CNT_W{1'b0}};
        end else if (clock_en) begin
            if (abort_take) begin
                captured_reg <= 1'b1;
                count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            end else if (clr_capt) begin
                captured_reg <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ### daes_top_monitor.sv
// Purpose: concurrent checks on the captured syndrome word
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every daes_top instance
`timescale 1ns/1ns
`default_nettype none
module daes_check (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // watched inputs
    input wire logic clock_en,
    input wire logic abort_take,
    input wire logic [2:0] fault_kind,
    input wire logic [1:0] lookup_level,
    input wire logic insn_cache_maint,
    input wire logic insn_addr_xlate,
    input wire logic insn_zero_op,
    input wire logic fault_stage2,
    // watched outputs
    input wire logic [24:0] syndrome_out,
    input wire logic syndrome_strobe
);
    wire take;
    assign take = abort_take && clock_en;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_cap;
        take ##1 (!abort_take && clock_en) |-> syndrome_strobe ##1 !syndrome_strobe;
    endproperty
    a_cap: assert property (p_cap) else $error("strobe not a single pulse");
    property p_wnr;
        take && (insn_cache_maint || insn_addr_xlate) |=> syndrome_out[8] && syndrome_out[6];
    endproperty
    a_wnr: assert property (p_wnr) else $error("maintenance op flags wrong");
    property p_cmz;
        take && insn_zero_op && !insn_cache_maint && !insn_addr_xlate |=> !syndrome_out[8];
    endproperty
    a_cmz: assert property (p_cmz) else $error("zeroing op set bit 8");
    property p_s1w;
        take && !fault_stage2 |=> !syndrome_out[7];
    endproperty
    a_s1w: assert property (p_s1w) else $error("walk flag without stage 2");
    property p_ea;
        take && fault_kind < 3'h4 |=> !syndrome_out[9];
    endproperty
    a_ea: assert property (p_ea) else $error("class bit on non-external abort");
    property p_res;
        syndrome_strobe && !syndrome_out[24] |-> syndrome_out[15:14] == 2'b00;
    endproperty
    a_res: assert property (p_res) else $error("flags set while invalid");
    property p_fnv;
        syndrome_strobe && syndrome_out[5:0] != 6'h10 |-> !syndrome_out[10];
    endproperty
    a_fnv: assert property (p_fnv) else $error("bit 10 set on other code");
    property p_typ;
        syndrome_strobe && syndrome_out[5:0] != 6'h10 && syndrome_out[5:0] != 6'h35
            |-> syndrome_out[12:11] == 2'b00;
    endproperty
    a_typ: assert property (p_typ) else $error("bits 12:11 set on other code");
    property p_tran;
        take && fault_kind == 3'h1 && lookup_level != 2'h3
            |=> syndrome_out[5:0] == {4'h1, $past(lookup_level)};
    endproperty
    a_tran: assert property (p_tran) else $error("translation code wrong");
    property p_addr;
        take && fault_kind == 3'h0 |=> syndrome_out[5:0] == {4'h0, $past(lookup_level)};
    endproperty
    a_addr: assert property (p_addr) else $error("address size code wrong");
endmodule
bind daes_top daes_check u_chk (.clock, .rst_n, .clock_en, .abort_take, .fault_kind,
    .lookup_level, .insn_cache_maint, .insn_addr_xlate, .insn_zero_op, .fault_stage2,
    .syndrome_out, .syndrome_strobe);
`default_nettype wire

// ### data_abort_syndrome_encoder_tb.sv
// Purpose: self-checking bench for the syndrome encoder
// Assumes: 25 MHz core clock, Avalon-MM register access
// Notes: attribute bits in fl are packed by the pipeline model
`timescale 1ns/1ns
`default_nettype none
module data_abort_syndrome_encoder_tb;
    logic clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic clock_en = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000, rd;
    wire [31:0] avs_readdata;
    wire [24:0] syndrome_out;
    wire [13:0] fl;
    wire [5:0] raw_code;
    wire [2:0] fault_kind;
    wire [1:0] lookup_level, error_state, insn_wide_form;
    wire avs_waitrequest, syndrome_strobe, abort_take, ext_class;
    int n_errors = 0, comparisons = 0, na = 0;
    always #20 clock = ~clock;

    daes_pipe_model PIPE (.clock, .abort_take, .fault_kind, .lookup_level, .raw_code,
        .error_state, .insn_wide_form, .ext_class, .fl);
    daes_top DUT (.clock, .rst_n, .clock_en, .abort_take, .fault_kind, .lookup_level,
        .raw_code, .insn_syndrome_ok(fl[13]), .insn_reg_64(fl[12]), .insn_acq_rel(fl[11]),
        .insn_is_write(fl[10]), .insn_is_atomic(fl[9]), .atomic_read_faults(fl[8]),
        .insn_wide(fl[7]), .insn_wide_form, .insn_cache_maint(fl[6]), .insn_addr_xlate(fl[5]),
        .insn_zero_op(fl[4]), .sysreg_redirect(fl[3]), .fault_stage2(fl[2]),
        .fault_on_walk(fl[1]), .far_valid(fl[0]), .error_state, .ext_class, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
        .avs_waitrequest, .syndrome_out, .syndrome_strobe);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int i;
        i = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) begin
            if (++i > 20) begin
                n_errors++;
                close_out;
            end
            @(posedge clock);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // an idle edge keeps a following call from reassigning in this time step
        @(posedge clock);
    endtask

    task automatic ab(input logic [2:0] k, input logic [1:0] l, input logic [13:0] f,
            input logic [1:0] e, input logic [1:0] w, input logic [24:0] m, input logic [24:0] x);
        PIPE.fire(k, l, f, e, w);
        na++;
        check({7'h00, syndrome_out & m}, {7'h00, x});
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        close_out;
    end

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        bus(0, 4'h4, 0);
        check(rd, 32'h0000_0000);
        bus(0, 4'hc, 0);
        check(rd, 32'h0000_0000);
        for (int i = 0; i < 3; i++) ab(1, i[1:0], 14'h3c00, 0, 0, 25'h100_c07f, 25'h100_c044 + i);
        for (int i = 0; i < 4; i++) ab(0, i[1:0], 14'h2000, 0, 0, 25'h100_c07f, 25'h100_0000 + i);
        ab(1, 1, 14'h1c00, 0, 0, 25'h100_c000, 0);
        bus(1, 4'h4, 32'h0000_0004);
        for (int j = 0; j < 3; j++) ab(4, 0, {13'h1000, j[0]}, (j == 0) ? 2'h0 : 2'(j + 1), 0, 25'h100_1c3f, {12'h0, (j == 0) ? 2'h0 : 2'(j + 1), ~j[0], 4'h0, 6'h10});
        ab(4, 0, 14'h2000, 2'h1, 0, 25'h100_1c3f, 25'h000_1410);
        bus(1, 4'h4, 32'h0000_0001);
        ab(3, 1, 14'h0880, 0, 3, 25'h100_d800, 25'h100_8000);
        for (int w = 1; w < 4; w++) ab(7, 0, 14'h0080, 0, w[1:0], 25'h000_183f, {12'h0, w[1:0], 5'h0, 6'h35});
        bus(1, 4'h4, 32'h0000_0002);
        ab(2, 1, 14'h0008, 0, 0, 25'h000_2000, 25'h000_2000);
        bus(1, 4'h4, 32'h0000_000a);
        ab(2, 1, 14'h0008, 0, 0, 25'h000_2000, 0);
        bus(1, 4'h4, 0);
        ab(3, 2, 14'h0040, 0, 0, 25'h000_0140, 25'h000_0140);
        ab(3, 2, 14'h0020, 0, 0, 25'h000_0140, 25'h000_0140);
        ab(3, 2, 14'h0410, 0, 0, 25'h000_0140, 25'h000_0040);
        ab(3, 2, 14'h0700, 0, 0, 25'h000_0040, 0);
        ab(3, 2, 14'h0600, 0, 0, 25'h000_0040, 25'h000_0040);
        ab(3, 2, 14'h0606, 0, 0, 25'h000_0040, 25'h000_0040);
        bus(1, 4'h4, 32'h0000_0010);
        ab(3, 2, 14'h0606, 0, 0, 25'h000_0040, 0);
        bus(1, 4'h4, 0);
        ab(1, 1, 14'h2006, 0, 0, 25'h100_0080, 25'h000_0080);
        ab(1, 1, 14'h2004, 0, 0, 25'h100_0080, 25'h100_0000);
        // an abort while the enable is low must leave the word untouched
        clock_en <= 1'b0;
        ab(3, 2, 14'h0040, 0, 0, 25'h1ff_ffff, 25'h100_0005);
        clock_en <= 1'b1;
        na--;
        bus(0, 4'h0, 0);
        check(rd & 32'h0100_ffff, 32'h0100_0005);
        bus(0, 4'h8, 0);
        check(rd & 32'h0000_ff01, {16'h0000, 8'(na), 8'h01});
        bus(1, 4'h8, 32'h0000_0001);
        bus(0, 4'h8, 0);
        check(rd & 32'h0000_0001, 32'h0000_0000);
        close_out;
    end
endmodule
`default_nettype wire
